// ---- core/dec_entry_ctrl.sv ----
// Debug state entry control with APB register access
//
// Operation
// - Breakpointed instruction enters execute, state change suppressed
// - Flushed breakpointed instruction and status are discarded
// - Entry starts at execute; acknowledge two cycles later
// - Prefetch abort wins over breakpoint
// - Breakpoint wins over software interrupt or undefined
// - Interrupt wins, breakpointed instruction discarded
// - Debug entry disables interrupts, mask bits untouched
// - Watchpoint lets next instruction finish; one-cycle delay after single-cycle data processing
// - Following instruction never executes; resume restarts there
// - Second-instruction prefetch abort handled before debug
// - Watchpoint entry leaves PC rewind of twenty
// - Aborted watchpointed access: latch, abort entry, debug
// - Pending interrupt entry runs before watchpoint debug
// - Debug request registered, beats pending interrupts
// - Request stops issue, waits for execute completion
// - Request halts even in monitor configuration
// - Debug state shows idle on both memory interfaces
// - Debug state ignores aborts and interrupts
// - Advance uses system enable, or debug enable halted
// - Test clock three-stage synchronised, returned clock handshake
// - Debug disabled blocks pin requests but not the APB halt write; acknowledge low
`timescale 1ns/10ps
module dec_entry_ctrl (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire dec_pkg::dec_pipe_type pipe,
  input  wire logic                 instr_breakpoint_in,
  input  wire logic                 data_watchpoint_in,
  input  wire logic                 external_halt_request,
  input  wire logic                 debug_enable_in,
  input  wire logic                 interrupt_request_low,
  input  wire logic                 fast_interrupt_request_low,
  input  wire logic                 system_clock_enable,
  input  wire logic                 debug_clock_enable,
  input  wire logic                 test_clock_in,
  output logic                      halt_acknowledge,
  output logic                      core_advance,
  output logic                      exec_suppress,
  output logic                      issue_stall,
  output logic                      prefetch_abort_take,
  output logic                      interrupt_take,
  output logic                      exception_suppress,
  output logic                      interrupts_disabled,
  output logic                      instr_mem_idle,
  output logic                      data_mem_idle,
  output logic                      debug_abort,
  output logic                      returned_test_clock
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]             sync1_ff;
  logic [2:0]             sync2_ff;
  logic [2:0]             sync3_ff;
  logic [2:0]             clean_ff;
  logic                   en;
  logic                   irq_pending;
  logic                   bp_fetch_ff;
  logic                   bp_dec_ff;
  logic                   pabt_dec_ff;
  logic                   exec_entry;
  logic                   wp_hit;
  logic                   req_ff;
  logic                   nxt_req_ff;
  logic                   wp_abort_ff;
  logic [1:0]             cnt_ff;
  dec_pkg::dec_state_type state_ff;
  dec_pkg::dec_state_type nxt_state;
  dec_pkg::dec_cause_type cause_ff;
  logic                   imprecise_ff;
  logic                   exc_first_ff;
  logic                   monitor_ff;
  logic                   bus_done;
  logic                   wr_ctrl;
  logic                   halt_wr;
  logic                   resume_wr;
  logic                   bkpt_start;
  logic                   bkpt_monitor;
  logic                   pabt_take;
  logic [31:0]            status_word;
  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic                   halt_ack_ff;
  logic                   core_adv_ff;
  logic                   suppress_ff;
  logic                   stall_ff;
  logic                   pabt_ff;
  logic                   irq_take_ff;
  logic                   exc_supp_ff;
  logic                   irq_dis_ff;
  logic                   idle_ff;
  logic                   dbg_abt_ff;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
      clean_ff <= 3'h0;
    end else begin
      sync1_ff <= {test_clock_in, debug_enable_in, external_halt_request};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      clean_ff <= (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & clean_ff);
    end
  end

  // Qualified requests
  assign en          = clean_ff[1];
  assign irq_pending = ~interrupt_request_low | ~fast_interrupt_request_low;

  // ----------------------------------------------------------------
  // Breakpoint tracking through fetch and decode
  // ----------------------------------------------------------------
  // Status follows its instruction; a flush drops both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_fetch_ff <= 1'b0;
      bp_dec_ff   <= 1'b0;
      pabt_dec_ff <= 1'b0;
    end else if (pipe.branch_flush) begin
      bp_fetch_ff <= 1'b0;
      bp_dec_ff   <= 1'b0;
      pabt_dec_ff <= 1'b0;
    end else begin
      if (pipe.pipeline_advance) begin
        bp_dec_ff   <= bp_fetch_ff;
        pabt_dec_ff <= pipe.fetch_prefetch_abort;
      end
      if (pipe.instr_sampled) begin
        bp_fetch_ff <= instr_breakpoint_in & en;
      end else if (pipe.pipeline_advance) begin
        bp_fetch_ff <= 1'b0;
      end
    end
  end

  // Instruction arrival at execute and data watch hits
  assign exec_entry   = pipe.pipeline_advance & bp_dec_ff & ~pipe.branch_flush;
  assign wp_hit       = data_watchpoint_in & en & pipe.data_access_done;
  assign pabt_take    = (state_ff == dec_pkg::DEC_ST_RUN) & ~req_ff & exec_entry
                        & pabt_dec_ff;
  assign bkpt_monitor = (state_ff == dec_pkg::DEC_ST_RUN) & ~req_ff & exec_entry
                        & ~pabt_dec_ff & ~irq_pending & monitor_ff;
  assign bkpt_start   = (state_ff == dec_pkg::DEC_ST_RUN) & ~req_ff & exec_entry
                        & ~pabt_dec_ff & ~irq_pending & ~monitor_ff;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign bus_done  = psel & penable & pready_ff;
  assign wr_ctrl   = bus_done & pwrite & (paddr == dec_pkg::DEC_CTRL_OFFSET);
  assign halt_wr   = wr_ctrl & pwdata[dec_pkg::DEC_CTRL_HALT_BIT];
  assign resume_wr = wr_ctrl & pwdata[dec_pkg::DEC_CTRL_RESUME_BIT];

  // Status word view
  always_comb begin
    status_word = 32'h00000000;
    status_word[dec_pkg::DEC_STAT_DEBUG_BIT] = (state_ff == dec_pkg::DEC_ST_HALTED);
    status_word[dec_pkg::DEC_STAT_CAUSE_LSB +: 2] = cause_ff;
    status_word[dec_pkg::DEC_STAT_IMPRECISE_BIT] = imprecise_ff;
    status_word[dec_pkg::DEC_STAT_EXC_FIRST_BIT] = exc_first_ff;
    if (cause_ff == dec_pkg::DEC_CAUSE_WPT) begin
      status_word[dec_pkg::DEC_STAT_REWIND_LSB +: 5] = dec_pkg::DEC_WPT_PC_REWIND;
    end
  end

  // One wait state; data and error loaded with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= 1'b0;
      if (psel & penable & ~pready_ff) begin
        if (paddr == dec_pkg::DEC_CTRL_OFFSET) begin
          prdata_ff <= {31'h00000000, monitor_ff};
        end else if (paddr == dec_pkg::DEC_STATUS_OFFSET) begin
          prdata_ff <= status_word;
        end else begin
          prdata_ff  <= 32'h00000000;
          pslverr_ff <= 1'b1;
        end
      end
    end
  end

  // Monitor configuration bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_ff <= dec_pkg::DEC_CTRL_RESET[dec_pkg::DEC_CTRL_MONITOR_BIT];
    end else if (wr_ctrl) begin
      monitor_ff <= pwdata[dec_pkg::DEC_CTRL_MONITOR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Debug request register
  // ----------------------------------------------------------------
  // Set wins over the clear taken at debug entry
  always_comb begin
    nxt_req_ff = req_ff;
    if (nxt_state == dec_pkg::DEC_ST_HALTED) begin
      nxt_req_ff = 1'b0;
    end
    if (state_ff != dec_pkg::DEC_ST_HALTED && ((clean_ff[0] & en) | halt_wr)) begin
      nxt_req_ff = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req_ff;
    end
  end

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dec_pkg::DEC_ST_RUN: begin
        if (req_ff) begin
          nxt_state = dec_pkg::DEC_ST_DRAIN;
        end else if (bkpt_start) begin
          nxt_state = dec_pkg::DEC_ST_BKPT;
        end else if (wp_hit & ~monitor_ff) begin
          nxt_state = dec_pkg::DEC_ST_WPT_NEXT;
        end
      end
      dec_pkg::DEC_ST_BKPT: begin
        if (cnt_ff == dec_pkg::DEC_BKPT_ACK_CYCLES - 2'h1) begin
          nxt_state = dec_pkg::DEC_ST_HALTED;
        end
      end
      dec_pkg::DEC_ST_WPT_NEXT: begin
        if (wp_abort_ff | irq_pending | pipe.fetch_prefetch_abort) begin
          nxt_state = dec_pkg::DEC_ST_EXC_WAIT;
        end else if (pipe.exec_done & pipe.exec_single_cycle_dp) begin
          nxt_state = dec_pkg::DEC_ST_WPT_DELAY;
        end else if (pipe.exec_done) begin
          nxt_state = dec_pkg::DEC_ST_HALTED;
        end
      end
      dec_pkg::DEC_ST_WPT_DELAY: begin
        nxt_state = dec_pkg::DEC_ST_HALTED;
      end
      dec_pkg::DEC_ST_EXC_WAIT: begin
        if (pipe.exception_entry_done) begin
          nxt_state = dec_pkg::DEC_ST_HALTED;
        end
      end
      dec_pkg::DEC_ST_DRAIN: begin
        if (pipe.exec_done) begin
          nxt_state = dec_pkg::DEC_ST_HALTED;
        end
      end
      dec_pkg::DEC_ST_HALTED: begin
        if (resume_wr & debug_clock_enable) begin
          nxt_state = dec_pkg::DEC_ST_RUN;
        end
      end
      default: begin
        nxt_state = dec_pkg::DEC_ST_RUN;
      end
    endcase
  end

  // State, entry counter and latched watchpoint abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= dec_pkg::DEC_ST_RUN;
      cnt_ff      <= 2'h0;
      wp_abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == dec_pkg::DEC_ST_BKPT) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else begin
        cnt_ff <= 2'h0;
      end
      if (state_ff == dec_pkg::DEC_ST_RUN) begin
        wp_abort_ff <= wp_hit & pipe.data_abort;
      end
    end
  end

  // Entry cause and flags for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff     <= dec_pkg::DEC_CAUSE_NONE;
      imprecise_ff <= 1'b0;
      exc_first_ff <= 1'b0;
    end else if (state_ff == dec_pkg::DEC_ST_RUN && nxt_state != dec_pkg::DEC_ST_RUN) begin
      exc_first_ff <= 1'b0;
      if (nxt_state == dec_pkg::DEC_ST_DRAIN) begin
        cause_ff     <= dec_pkg::DEC_CAUSE_REQ;
        imprecise_ff <= 1'b0;
      end else if (nxt_state == dec_pkg::DEC_ST_BKPT) begin
        cause_ff     <= dec_pkg::DEC_CAUSE_BKPT;
        imprecise_ff <= 1'b0;
      end else begin
        cause_ff     <= dec_pkg::DEC_CAUSE_WPT;
        imprecise_ff <= 1'b1;
      end
    end else if (nxt_state == dec_pkg::DEC_ST_EXC_WAIT) begin
      exc_first_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Core-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_ack_ff <= 1'b0;
      core_adv_ff <= 1'b0;
      suppress_ff <= 1'b0;
      stall_ff    <= 1'b0;
      irq_dis_ff  <= 1'b0;
      idle_ff     <= 1'b0;
      irq_take_ff <= 1'b0;
    end else begin
      halt_ack_ff <= en & (nxt_state == dec_pkg::DEC_ST_HALTED);
      core_adv_ff <= (nxt_state == dec_pkg::DEC_ST_HALTED) ? debug_clock_enable
                                                           : system_clock_enable;
      suppress_ff <= (nxt_state == dec_pkg::DEC_ST_BKPT)
                   | (nxt_state == dec_pkg::DEC_ST_WPT_DELAY)
                   | (nxt_state == dec_pkg::DEC_ST_HALTED);
      stall_ff    <= (nxt_state == dec_pkg::DEC_ST_DRAIN);
      irq_dis_ff  <= (nxt_state == dec_pkg::DEC_ST_HALTED);
      idle_ff     <= (nxt_state == dec_pkg::DEC_ST_HALTED);
      irq_take_ff <= irq_pending & ~nxt_req_ff & ~bkpt_start
                   & (nxt_state != dec_pkg::DEC_ST_HALTED)
                   & (nxt_state != dec_pkg::DEC_ST_BKPT);
    end
  end

  // Exception pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pabt_ff     <= 1'b0;
      exc_supp_ff <= 1'b0;
      dbg_abt_ff  <= 1'b0;
    end else begin
      pabt_ff     <= pabt_take;
      exc_supp_ff <= bkpt_start & pipe.decode_is_softint_undef;
      dbg_abt_ff  <= bkpt_monitor | ((state_ff == dec_pkg::DEC_ST_RUN) & ~req_ff
                     & wp_hit & monitor_ff);
    end
  end

  // Port drive
  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign halt_acknowledge    = halt_ack_ff;
  assign core_advance        = core_adv_ff;
  assign exec_suppress       = suppress_ff;
  assign issue_stall         = stall_ff;
  assign prefetch_abort_take = pabt_ff;
  assign interrupt_take      = irq_take_ff;
  assign exception_suppress  = exc_supp_ff;
  assign interrupts_disabled = irq_dis_ff;
  assign instr_mem_idle      = idle_ff;
  assign data_mem_idle       = idle_ff;
  assign debug_abort         = dbg_abt_ff;
  assign returned_test_clock = clean_ff[2];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bkpt_ack;
    @(posedge pclk) disable iff (!presetn)
    bkpt_start |-> ##3 (halt_acknowledge || !en);
  endproperty
  a_bkpt_ack: assert property (p_bkpt_ack) else $error("ack not two cycles after entry");

  property p_flush;
    @(posedge pclk) disable iff (!presetn)
    pipe.branch_flush |=> (!bp_dec_ff && !bp_fetch_ff);
  endproperty
  a_flush: assert property (p_flush) else $error("breakpoint kept after flush");

  property p_pabt_first;
    @(posedge pclk) disable iff (!presetn)
    pabt_take |=> (prefetch_abort_take && state_ff == dec_pkg::DEC_ST_RUN);
  endproperty
  a_pabt_first: assert property (p_pabt_first) else $error("breakpoint beat prefetch abort");

  property p_irq_wins;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dec_pkg::DEC_ST_RUN && !req_ff && exec_entry && !pabt_dec_ff && irq_pending)
    |=> (state_ff == dec_pkg::DEC_ST_RUN);
  endproperty
  a_irq_wins: assert property (p_irq_wins) else $error("interrupt lost to breakpoint");

  property p_halted_quiet;
    @(posedge pclk) disable iff (!presetn)
    halt_acknowledge |-> (interrupts_disabled && !interrupt_take && exec_suppress);
  endproperty
  a_halted_quiet: assert property (p_halted_quiet) else $error("interrupt seen halted");

  property p_dp_delay;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dec_pkg::DEC_ST_WPT_DELAY) |=> (state_ff == dec_pkg::DEC_ST_HALTED)
    ##1 (halt_acknowledge || !$past(en));
  endproperty
  a_dp_delay: assert property (p_dp_delay) else $error("watchpoint delay wrong");

  property p_req_priority;
    @(posedge pclk) disable iff (!presetn)
    req_ff |-> !interrupt_take;
  endproperty
  a_req_priority: assert property (p_req_priority) else $error("interrupt beat request");

  property p_drain;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dec_pkg::DEC_ST_DRAIN && !pipe.exec_done) |=>
    (issue_stall && state_ff == dec_pkg::DEC_ST_DRAIN);
  endproperty
  a_drain: assert property (p_drain) else $error("halted before execute finished");

  property p_idle;
    @(posedge pclk) disable iff (!presetn)
    halt_acknowledge |-> (instr_mem_idle && data_mem_idle);
  endproperty
  a_idle: assert property (p_idle) else $error("memory not idle in debug");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    !en |=> !halt_acknowledge;
  endproperty
  a_disabled: assert property (p_disabled) else $error("ack high while disabled");

  property p_rewind;
    @(posedge pclk) disable iff (!presetn)
    (cause_ff == dec_pkg::DEC_CAUSE_WPT) |-> (status_word[12:8] == 5'h14);
  endproperty
  a_rewind: assert property (p_rewind) else $error("wrong watchpoint rewind");

endmodule // dec_entry_ctrl

// ---- core/dec_pkg.sv ----
// Constants, types and carrier structs for the debug entry control block
package dec_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] DEC_CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] DEC_STATUS_OFFSET = 12'h004;
  localparam logic [31:0] DEC_CTRL_RESET    = 32'h00000000;

  // Control fields
  localparam int DEC_CTRL_MONITOR_BIT = 0;
  localparam int DEC_CTRL_HALT_BIT    = 1;
  localparam int DEC_CTRL_RESUME_BIT  = 2;

  // Status fields
  localparam int DEC_STAT_DEBUG_BIT     = 0;
  localparam int DEC_STAT_CAUSE_LSB     = 1;
  localparam int DEC_STAT_IMPRECISE_BIT = 3;
  localparam int DEC_STAT_EXC_FIRST_BIT = 4;
  localparam int DEC_STAT_REWIND_LSB    = 8;

  // ----------------------------------------------------------------
  // Timing and values
  // ----------------------------------------------------------------
  localparam logic [1:0] DEC_BKPT_ACK_CYCLES = 2'h2;
  localparam logic [4:0] DEC_WPT_PC_REWIND   = 5'h14;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEC_CAUSE_NONE,
    DEC_CAUSE_BKPT,
    DEC_CAUSE_WPT,
    DEC_CAUSE_REQ
  } dec_cause_type;

  typedef enum {
    DEC_ST_RUN,
    DEC_ST_BKPT,
    DEC_ST_WPT_NEXT,
    DEC_ST_WPT_DELAY,
    DEC_ST_EXC_WAIT,
    DEC_ST_DRAIN,
    DEC_ST_HALTED
  } dec_state_type;

  // Pipeline events from the core, all on pclk
  typedef struct packed {
    logic instr_sampled;
    logic pipeline_advance;
    logic branch_flush;
    logic fetch_prefetch_abort;
    logic decode_is_softint_undef;
    logic data_access_done;
    logic data_abort;
    logic exec_single_cycle_dp;
    logic exec_done;
    logic exception_entry_done;
  } dec_pipe_type;

endpackage

// ---- verification/dec_sys_model.sv ----
// Partner model: pipeline events, comparators, test clock source
`timescale 1ns/10ps
module dec_sys_model (
  input  wire logic             pclk,
  input  wire logic             returned_test_clock,
  output dec_pkg::dec_pipe_type pipe,
  output logic                  instr_breakpoint_in,
  output logic                  data_watchpoint_in,
  output logic                  test_clock_in
);
  int n_tck;
  // Quiet pipeline at time zero
  initial begin
    pipe = '0;
    instr_breakpoint_in = 1'b0;
    data_watchpoint_in = 1'b0;
  end
  // Next test clock edge only after the returned one
  initial begin
    test_clock_in = 1'b0;
    n_tck = 0;
    forever begin
      @(posedge pclk);
      if (returned_test_clock === test_clock_in) begin
        test_clock_in <= !test_clock_in;
        n_tck <= n_tck + 1;
      end
    end
  end
  // One cycle of events; comparator outputs in the same cycle
  task automatic step(input logic [9:0] p, input logic bp, input logic wp);
    @(posedge pclk);
    pipe <= dec_pkg::dec_pipe_type'(p);
    instr_breakpoint_in <= bp;
    data_watchpoint_in <= wp;
  endtask
endmodule // dec_sys_model

// ---- verification/testbench.sv ----
// Self-checking bench for the debug entry control block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, a); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  dec_pkg::dec_pipe_type pipe;
  logic instr_breakpoint_in, data_watchpoint_in, external_halt_request;
  logic debug_enable_in, interrupt_request_low, fast_interrupt_request_low;
  logic system_clock_enable, debug_clock_enable, test_clock_in;
  logic halt_acknowledge, core_advance, exec_suppress, issue_stall;
  logic prefetch_abort_take, interrupt_take, exception_suppress;
  logic interrupts_disabled, instr_mem_idle, data_mem_idle;
  logic debug_abort, returned_test_clock, ha;
  int n_errors, checked, k;
  int n[3];
  dec_entry_ctrl dut_u (.*);
  dec_sys_model sys_u (.*);
  always #50 pclk = !pclk;
  // APB transfer held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // Wait for acknowledge, bounded
  task automatic wait_ack();
    k = 0;
    while (halt_acknowledge !== 1'b1 && k < 30) begin
      @(posedge pclk);
      k++;
    end
  endtask
  // Resume from debug state
  task automatic resume();
    apb(1'b1, dec_pkg::DEC_CTRL_OFFSET, 32'h4);
    repeat (3) @(posedge pclk);
    `CHK("resume", 1'b0, halt_acknowledge)
  endtask
  task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {external_halt_request, debug_enable_in} = 2'h1;
    {interrupt_request_low, fast_interrupt_request_low} = 2'h3;
    {system_clock_enable, debug_clock_enable} = 2'h3;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, dec_pkg::DEC_CTRL_OFFSET, 32'h0);
    `CHK("ctrl", dec_pkg::DEC_CTRL_RESET, r)
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("unmapped", 1'b1, e)
    system_clock_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("advance", 1'b0, core_advance)
    system_clock_enable <= 1'b1;
    $display("test registers done");
    // Breakpoint cases: plain, flush, abort, interrupt, disabled, swi
    for (int i = 0; i < 6; i++) begin
      ha = (i == 0 || i == 5);
      interrupt_request_low <= (i != 3);
      debug_enable_in <= (i != 4);
      repeat (6) @(posedge pclk);
      sys_u.step(10'h200, 1'b1, 1'b0);
      sys_u.step(10'h100 | ((i == 2) ? 10'h040 : 10'h0), 1'b0, 1'b0);
      sys_u.step((i == 1) ? 10'h080 : ((i == 5) ? 10'h120 : 10'h100), 1'b0, 1'b0);
      sys_u.step(10'h000, 1'b0, 1'b0);
      #1;
      `CHK("pabt", (i == 2), prefetch_abort_take)
      `CHK("softint", (i == 5), exception_suppress)
      @(posedge pclk);
      #1;
      `CHK("suppress", ha, exec_suppress)
      `CHK("early", 1'b0, halt_acknowledge)
      @(posedge pclk);
      #1;
      `CHK("ack", ha, halt_acknowledge)
      if (ha) begin
        `CHK("idle", 3'h7, {interrupts_disabled, instr_mem_idle, data_mem_idle})
        interrupt_request_low <= 1'b0;
        debug_clock_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("irq", 1'b0, interrupt_take)
        `CHK("dbgadv", 1'b0, core_advance)
        {interrupt_request_low, debug_clock_enable} <= 2'h3;
        apb(1'b0, dec_pkg::DEC_STATUS_OFFSET, 32'h0);
        `CHK("bstat", 32'h3, r & 32'h7)
        resume();
      end
    end
    $display("test breakpoint done");
    // Watchpoint: plain, single-cycle data processing, aborted access
    for (int dp = 0; dp < 3; dp++) begin
      sys_u.step(10'h010 | ((dp == 2) ? 10'h008 : 10'h0), 1'b0, 1'b1);
      sys_u.step({7'h0, dp[0], 2'h2}, 1'b0, 1'b0);
      sys_u.step((dp == 2) ? 10'h001 : 10'h000, 1'b0, 1'b0);
      wait_ack();
      n[dp] = k;
      `CHK("wack", 1'b1, halt_acknowledge)
      apb(1'b0, dec_pkg::DEC_STATUS_OFFSET, 32'h0);
      `CHK("wstat", (dp == 2) ? 32'h1415 : 32'h1405, r & 32'h1F17)
      resume();
    end
    `CHK("wdelay", 1, n[1] - n[0])
    $display("test watchpoint done");
    // Pin request in monitor mode with an interrupt pending
    apb(1'b1, dec_pkg::DEC_CTRL_OFFSET, 32'h1);
    sys_u.step(10'h010, 1'b0, 1'b1);
    sys_u.step(10'h000, 1'b0, 1'b0);
    #1;
    `CHK("monabort", 1'b1, debug_abort)
    `CHK("monrun", 1'b0, halt_acknowledge)
    {external_halt_request, interrupt_request_low} <= 2'h2;
    k = 0;
    while (issue_stall !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    `CHK("stall", 1'b1, issue_stall)
    `CHK("drain", 1'b0, halt_acknowledge)
    external_halt_request <= 1'b0;
    sys_u.step(10'h002, 1'b0, 1'b0);
    sys_u.step(10'h000, 1'b0, 1'b0);
    wait_ack();
    `CHK("rack", 1'b1, halt_acknowledge)
    apb(1'b0, dec_pkg::DEC_STATUS_OFFSET, 32'h0);
    `CHK("rstat", 32'h7, r & 32'h7)
    interrupt_request_low <= 1'b1;
    resume();
    `CHK("tck", 1'b1, sys_u.n_tck > 4)
    $display("test request done");
    conclude();
  end
endmodule // testbench
